// ---- hw/iq_mux_sample_port.sv ----
// Digital sample port of a dual receive and dual transmit converter pair:
// multiplexed receive output bus, multiplexed transmit input bus.
// Assumes the conversion clock and all pins are synchronous to sys_clk_i
// and run at most half the system clock rate.
//
// Summary of operation
// - Both receive channels sampled together on conversion rising edge.
// - One output bus: in-phase on rising, quadrature on falling edge.
// - Latency: five cycles for in-phase, five and a half for quadrature.
// - Receive samples advance a stage every half conversion cycle.
// - Receive words are ten-bit offset binary, zero at midscale.
// - Receive bus floats in power states and two serial states.
// - Both transmit channels share one ten-bit bus, words alternating.
// - In-phase transmit word is captured on the falling conversion edge.
// - Quadrature word on rising edge; both outputs update together.
// - Transmit: 1023 top, 0 bottom, zero between 511 and 512.
// - Transmit path accepts conversion clocks up to half the system clock, 10 MHz at 20 MHz.
// - Each bus, receive and transmit, is disabled on its own.
// - Offset trim per transmit channel; selectable common-mode level.
// - Receive bus bit 9 is the MSB, bit 0 the LSB.
// - Undriven transmit bus lines read high through weak pull-ups.
`timescale 1ns/1ps
`default_nettype none
module iq_mux_sample_port (
  input wire logic sys_clk_i,
  input wire logic rst_i,
  input wire logic conv_clk_i,
  input wire logic [9:0] rx_inphase_channel_i,
  input wire logic [9:0] rx_quadrature_channel_i,
  input wire logic rx_core_valid_i,
  output logic rx_core_ready_o,
  input wire logic powerdown_state_i,
  input wire logic idle_state_i,
  input wire logic reference_only_state_i,
  input wire logic serial_cfg_state_b_i,
  input wire logic serial_cfg_state_d_i,
  input wire logic rx_bus_enable_i,
  input wire logic tx_bus_enable_i,
  input wire logic [5:0] tx_inphase_offset_i,
  input wire logic [5:0] tx_quadrature_offset_i,
  input wire logic [1:0] tx_common_mode_sel_i,
  output logic [9:0] rx_sample_bus_o,
  output logic rx_sample_bus_oe_o,
  input wire logic [9:0] tx_sample_bus_i,
  input wire logic tx_sample_bus_driven_i,
  output logic [9:0] tx_inphase_channel_o,
  output logic [9:0] tx_quadrature_channel_o,
  output logic tx_update_o,
  output logic [1:0] tx_common_mode_o
);
  localparam int W = iq_port_pkg::WORD_W;
  localparam int PW = iq_port_pkg::PAIR_W;
  localparam int NS = iq_port_pkg::PIPE_STAGES;

  // Saturating offset trim, offset is two's complement
  function automatic logic [9:0] trim(input logic [9:0] code,
                                      input logic [5:0] off);
    logic signed [11:0] sum;
    sum = $signed({2'b00, code}) + $signed({{6{off[5]}}, off});
    if (sum < 0) begin
      trim = iq_port_pkg::CODE_NEG_FULL;
    end else if (sum > $signed({2'b00, iq_port_pkg::CODE_POS_FULL})) begin
      trim = iq_port_pkg::CODE_POS_FULL;
    end else begin
      trim = sum[9:0];
    end
  endfunction

  // Conversion clock edges
  logic conv_q;
  wire rise_edge = conv_clk_i && !conv_q;
  wire fall_edge = !conv_clk_i && conv_q;
  wire any_edge = rise_edge || fall_edge;

  always_ff @(posedge sys_clk_i) begin
    if (rst_i) conv_q <= 1'b0;
    else conv_q <= conv_clk_i;
  end

  // Receive side
  wire rx_off = powerdown_state_i || idle_state_i || reference_only_state_i
    || serial_cfg_state_b_i || serial_cfg_state_d_i || !rx_bus_enable_i;
  wire core_active = !powerdown_state_i && !idle_state_i
    && !reference_only_state_i;
  wire fifo_valid;
  wire [PW-1:0] fifo_data;
  // Drained once per rising edge; an empty FIFO repeats the last pair
  wire fifo_pop = rise_edge && core_active;

  rx_sample_fifo #(
    .WIDTH(PW),
    .DEPTH(iq_port_pkg::FIFO_DEPTH)
  ) u_rx_fifo (
    .sys_clk_i(sys_clk_i),
    .rst_i(rst_i),
    .in_valid_i(rx_core_valid_i),
    .in_ready_o(rx_core_ready_o),
    .in_data_i({rx_inphase_channel_i, rx_quadrature_channel_i}),
    .out_valid_o(fifo_valid),
    .out_ready_i(fifo_pop),
    .out_data_o(fifo_data)
  );

  wire [W-1:0] fifo_i = fifo_data[PW-1:W];
  wire [W-1:0] fifo_q = fifo_data[W-1:0];
  logic [W-1:0] pipe_i [NS];
  logic [W-1:0] pipe_q [NS];

  always_ff @(posedge sys_clk_i) begin
    if (rst_i) begin
      pipe_i[0] <= iq_port_pkg::CODE_ZERO;
      pipe_q[0] <= iq_port_pkg::CODE_ZERO;
    end else if (fifo_pop && fifo_valid) begin
      pipe_i[0] <= fifo_i;
      pipe_q[0] <= fifo_q;
    end
  end

  genvar s;
  generate
    for (s = 1; s < NS; s++) begin : g_pipe
      always_ff @(posedge sys_clk_i) begin
        if (rst_i) begin
          pipe_i[s] <= iq_port_pkg::CODE_ZERO;
          pipe_q[s] <= iq_port_pkg::CODE_ZERO;
        end else if (any_edge && core_active) begin
          pipe_i[s] <= pipe_i[s-1];
          pipe_q[s] <= pipe_q[s-1];
        end
      end
    end
  endgenerate

  // Bus keeps updating while floated outside the power states, so the last word shows on enable
  logic [W-1:0] rx_word_q;
  wire [W-1:0] rx_word_d = rise_edge ? pipe_i[iq_port_pkg::I_OUT_TAP]
                                     : pipe_q[iq_port_pkg::Q_OUT_TAP];

  always_ff @(posedge sys_clk_i) begin
    if (rst_i) rx_word_q <= iq_port_pkg::CODE_ZERO;
    else if (any_edge && core_active) rx_word_q <= rx_word_d;
  end

  // Offset-binary word passes straight out, bit 9 the MSB
  assign rx_sample_bus_o = rx_word_q;
  assign rx_sample_bus_oe_o = !rx_off;

  // Transmit side
  wire tx_on = tx_bus_enable_i && !powerdown_state_i && !idle_state_i
    && !reference_only_state_i;
  wire [W-1:0] tx_bus_eff = tx_sample_bus_driven_i ? tx_sample_bus_i
                          : iq_port_pkg::PULLUP_WORD;

  iq_port_pkg::tx_phase_t phase_q;
  iq_port_pkg::tx_phase_t phase_d;
  logic [W-1:0] tx_i_hold_q;
  logic [W-1:0] tx_i_out_q;
  logic [W-1:0] tx_q_out_q;
  logic tx_update_q;
  logic [1:0] cm_q;
  wire tx_fire = rise_edge && tx_on && (phase_q == iq_port_pkg::TX_HAVE_I);
  // Trim is applied at the update, not at capture, so while enabled the outputs move only on an update
  wire [W-1:0] tx_i_trim =
    trim(tx_i_hold_q, tx_inphase_offset_i);
  wire [W-1:0] tx_q_trim =
    trim(tx_bus_eff, tx_quadrature_offset_i);

  always_comb begin
    phase_d = phase_q;
    unique case (phase_q)
      iq_port_pkg::TX_WAIT_I: if (fall_edge && tx_on) begin
        phase_d = iq_port_pkg::TX_HAVE_I;
      end
      iq_port_pkg::TX_HAVE_I: if (!tx_on) begin
        phase_d = iq_port_pkg::TX_WAIT_I;
      end
    endcase
  end

  // Words alternate on the shared bus; setup by the processor is assumed
  always_ff @(posedge sys_clk_i) begin
    if (rst_i || !tx_on) begin
      phase_q <= iq_port_pkg::TX_WAIT_I;
      tx_i_hold_q <= iq_port_pkg::CODE_ZERO; // Held data lost when off
    end else begin
      phase_q <= phase_d;
      if (fall_edge) tx_i_hold_q <= tx_bus_eff;
    end
  end

  always_ff @(posedge sys_clk_i) begin
    if (rst_i || !tx_on) begin
      tx_i_out_q <= iq_port_pkg::CODE_ZERO;
      tx_q_out_q <= iq_port_pkg::CODE_ZERO;
    end else if (tx_fire) begin
      tx_i_out_q <= tx_i_trim;
      tx_q_out_q <= tx_q_trim;
    end
  end

  always_ff @(posedge sys_clk_i) begin
    if (rst_i) begin
      tx_update_q <= 1'b0;
      cm_q <= '0;
    end else begin
      tx_update_q <= tx_fire;
      cm_q <= tx_common_mode_sel_i;
    end
  end

  // Midscale codes 512/511 straddle zero; outputs rest at midscale
  assign tx_inphase_channel_o = tx_i_out_q;
  assign tx_quadrature_channel_o = tx_q_out_q;
  assign tx_update_o = tx_update_q;
  assign tx_common_mode_o = cm_q;

  // Cycles since the last transmit update, saturating; checker helper only
  localparam logic [1:0] MIN_GAP = 2'(iq_port_pkg::CONV_MIN_SYS_CYCLES - 1);
  logic [1:0] gap_q;

  always_ff @(posedge sys_clk_i) begin
    if (rst_i) begin
      gap_q <= '1;
    end else if (tx_fire) begin
      gap_q <= '0;
    end else if (gap_q != '1) begin
      gap_q <= gap_q + 1'b1;
    end
  end

  // Checks
  default clocking cb @(posedge sys_clk_i); endclocking
  default disable iff (rst_i);

  sample_both_a: assert property (
    fifo_pop && fifo_valid |=> pipe_i[0] == $past(fifo_i)
      && pipe_q[0] == $past(fifo_q))
    else $error("receive pair not sampled together");

  bus_edge_only_a: assert property (
    !any_edge |=> $stable(rx_word_q))
    else $error("receive bus changed off a conversion edge");

  i_word_rise_a: assert property (
    rise_edge && core_active |=>
      rx_word_q == $past(pipe_i[iq_port_pkg::I_OUT_TAP]))
    else $error("in-phase word not from its tap on rising edge");

  q_word_fall_a: assert property (
    fall_edge && core_active |=>
      rx_word_q == $past(pipe_q[iq_port_pkg::Q_OUT_TAP]))
    else $error("quadrature word not from its tap on falling edge");

  pipe_step_a: assert property (
    fall_edge && core_active |=>
      pipe_q[NS-1] == $past(pipe_q[NS-2]))
    else $error("pipeline did not advance on half cycle");

  rx_float_a: assert property (
    rx_off |-> !rx_sample_bus_oe_o)
    else $error("receive bus driven while disabled");

  tx_i_capture_a: assert property (
    fall_edge && tx_on ##1 tx_on |-> tx_i_hold_q == $past(tx_bus_eff))
    else $error("in-phase transmit word not captured on falling edge");

  tx_joint_update_a: assert property (
    tx_fire |=> tx_update_o && tx_quadrature_channel_o ==
      trim($past(tx_bus_eff), $past(tx_quadrature_offset_i)))
    else $error("transmit outputs not updated together");

  tx_rate_a: assert property (
    tx_update_o |=> !tx_update_o)
    else $error("transmit updates faster than conversion rate");

  pullup_a: assert property (
    fall_edge && tx_on && !tx_sample_bus_driven_i |=>
      tx_i_hold_q == iq_port_pkg::PULLUP_WORD)
    else $error("undriven transmit bus not read high");

  tx_idle_mid_a: assert property (
    !tx_on |=> tx_inphase_channel_o == iq_port_pkg::CODE_ZERO
      && tx_quadrature_channel_o == iq_port_pkg::CODE_ZERO
      && !tx_update_o)
    else $error("disabled transmit path not at midscale");

  // Receive checks
  pipe_step_i_a: assert property (
    rise_edge && core_active |=> pipe_i[NS-1] == $past(pipe_i[NS-2]))
    else $error("in-phase pipeline did not advance on half cycle");

  pipe_entry_a: assert property (
    !rise_edge |=> $stable(pipe_i[0]) && $stable(pipe_q[0]))
    else $error("receive pair entered off a rising edge");

  rx_freeze_a: assert property (
    !core_active |=> $stable(rx_word_q) && $stable(pipe_q[NS-1]))
    else $error("receive path moved in a low-power state");

  rx_drive_a: assert property (
    !rx_off |-> rx_sample_bus_oe_o)
    else $error("enabled receive bus not driven");

  fifo_stall_a: assert property (
    !rx_core_ready_o |-> fifo_valid)
    else $error("receive buffer full yet empty");

  // Transmit checks
  tx_i_update_a: assert property (
    tx_fire |=> tx_inphase_channel_o == trim($past(tx_i_hold_q),
      $past(tx_inphase_offset_i)))
    else $error("in-phase transmit output not updated with quadrature");

  tx_hold_a: assert property (
    tx_on && !tx_fire |=> $stable(tx_inphase_channel_o)
      && $stable(tx_quadrature_channel_o))
    else $error("transmit output changed without an update");

  tx_needs_fall_a: assert property (
    tx_update_o |-> $past(phase_q == iq_port_pkg::TX_HAVE_I))
    else $error("transmit update without a preceding in-phase word");

  tx_off_clear_a: assert property (
    !tx_on |=> tx_i_hold_q == iq_port_pkg::CODE_ZERO)
    else $error("held transmit word kept while disabled");

  cm_follow_a: assert property (
    1'b1 |=> tx_common_mode_o == $past(tx_common_mode_sel_i))
    else $error("common-mode select not passed on");

  tx_gap_a: assert property (
    tx_fire |-> gap_q >= MIN_GAP)
    else $error("transmit updates closer than one conversion period");

  rx_word_out_c: cover property (rx_sample_bus_oe_o && rise_edge);
  tx_update_c: cover property (tx_update_o);
  fifo_full_c: cover property (!rx_core_ready_o);
  rx_reenable_c: cover property (rx_off ##1 !rx_off);
  tx_released_c: cover property (tx_fire && !tx_sample_bus_driven_i);
endmodule
`default_nettype wire

// ---- hw/iq_port_pkg.sv ----
// Shared constants of the I/Q sample port: word coding, pipeline taps,
// trim widths and rates.
// Assumes one system clock; the conversion clock arrives as a level.
package iq_port_pkg;
  localparam int WORD_W = 10;
  localparam int OFFSET_W = 6;
  localparam int CM_W = 2;
  localparam int FIFO_DEPTH = 4;
  localparam int PAIR_W = 2 * WORD_W;
  // Offset-binary reference codes
  localparam logic [9:0] CODE_ZERO = 10'h200;
  localparam logic [9:0] CODE_POS_FULL = 10'h3FF;
  localparam logic [9:0] CODE_NEG_FULL = 10'h000;
  localparam logic [9:0] PULLUP_WORD = 10'h3FF;
  // Receive pipeline, counted in half conversion cycles
  localparam int PIPE_STAGES = 11;
  localparam int I_OUT_TAP = 9;
  localparam int Q_OUT_TAP = 10;
  // Rates
  localparam int SYS_CLK_MHZ = 20;
  localparam int TX_MAX_CONV_MHZ = 45;
  // Two system cycles per conversion period is the best this port can see
  localparam int CONV_MIN_SYS_CYCLES = 2;
  typedef enum logic [0:0] {TX_WAIT_I, TX_HAVE_I} tx_phase_t;
endpackage

// ---- hw/rx_sample_fifo.sv ----
// Small FIFO that holds receive sample pairs ahead of the pipeline.
// Assumes one clock, synchronous active-high reset.
`timescale 1ns/1ps
`default_nettype none
module rx_sample_fifo #(
  parameter int WIDTH = 20,
  parameter int DEPTH = 4
) (
  input wire logic sys_clk_i,
  input wire logic rst_i,
  input wire logic in_valid_i,
  output logic in_ready_o,
  input wire logic [WIDTH-1:0] in_data_i,
  output logic out_valid_o,
  input wire logic out_ready_i,
  output logic [WIDTH-1:0] out_data_o
);
  localparam int PTR_W = $clog2(DEPTH);
  localparam int CNT_W = PTR_W + 1;
  localparam logic [CNT_W-1:0] FULL_CNT = CNT_W'(DEPTH);
  localparam logic [PTR_W-1:0] LAST_PTR = PTR_W'(DEPTH - 1);

  logic [WIDTH-1:0] mem_q [DEPTH];
  logic [PTR_W-1:0] wr_ptr_q;
  logic [PTR_W-1:0] rd_ptr_q;
  logic [CNT_W-1:0] count_q;
  wire push = in_valid_i && in_ready_o;
  wire pop = out_valid_o && out_ready_i;
  wire [PTR_W-1:0] wr_next = (wr_ptr_q == LAST_PTR) ? '0 : wr_ptr_q + 1'b1;
  wire [PTR_W-1:0] rd_next = (rd_ptr_q == LAST_PTR) ? '0 : rd_ptr_q + 1'b1;

  assign in_ready_o = (count_q != FULL_CNT);
  assign out_valid_o = (count_q != '0);
  assign out_data_o = mem_q[rd_ptr_q];

  always_ff @(posedge sys_clk_i) begin
    if (push) begin
      mem_q[wr_ptr_q] <= in_data_i;
    end
  end

  always_ff @(posedge sys_clk_i) begin
    if (rst_i) begin
      wr_ptr_q <= '0;
      rd_ptr_q <= '0;
      count_q <= '0;
    end else begin
      if (push) wr_ptr_q <= wr_next;
      if (pop) rd_ptr_q <= rd_next;
      if (push && !pop) count_q <= count_q + 1'b1;
      else if (pop && !push) count_q <= count_q - 1'b1;
    end
  end
endmodule
`default_nettype wire

// ---- sim/baseband_model.sv ----
// Baseband processor model: makes the conversion clock, drives the
// multiplexed transmit bus and announces each word pair it sends.
// Assumes the system clock; it acts on falling edges only.
`timescale 1ns/1ps
`default_nettype none
module baseband_model (
  input wire logic sys_clk_i,
  input wire logic rst_i,
  input wire logic run_i,
  input wire logic release_i,
  input wire logic [9:0] i_word_i,
  input wire logic [9:0] q_word_i,
  output logic conv_clk_o,
  output logic [9:0] tx_bus_o,
  output logic tx_driven_o,
  output logic pair_o,
  output logic [9:0] pair_i_o,
  output logic [9:0] pair_q_o
);
  logic [1:0] cnt_q;
  logic rel_q;
  logic i_phase;
  // Stops just after a rising edge, so no pair is left half sent
  always @(negedge sys_clk_i) begin
    pair_o <= !rst_i && run_i && cnt_q == 2'h2;
    if (rst_i) begin
      cnt_q <= 2'h0;
      rel_q <= 1'b0;
      pair_i_o <= 10'h000;
      pair_q_o <= 10'h000;
    end else if (run_i || cnt_q != 2'h2) begin
      cnt_q <= cnt_q + 2'h1;
      if (cnt_q == 2'h2) begin
        rel_q <= release_i;
        pair_i_o <= release_i ? 10'h3FF : i_word_i;
        pair_q_o <= release_i ? 10'h3FF : q_word_i;
      end
    end
  end
  assign conv_clk_o = cnt_q[1];
  // I stands before the falling edge, Q before the rising edge
  assign i_phase = cnt_q[1] == cnt_q[0];
  // A released bus shows the inverse, never the last word
  assign tx_bus_o = (i_phase ? pair_i_o : pair_q_o) ^ {10{rel_q}};
  assign tx_driven_o = !rel_q;
endmodule
`default_nettype wire

// ---- sim/testbench.sv ----
// Self-checking bench for the I/Q sample port.
// Assumes the package, the design and the baseband model come first.
`timescale 1ns/1ps
`default_nettype none
module testbench;
  logic sys_clk = 1'b0;
  logic rst_i = 1'b1;
  logic run = 1'b0;
  logic rel = 1'b0;
  logic rx_valid = 1'b0;
  logic [9:0] rx_i = 10'h000;
  logic [9:0] rx_q = 10'h000;
  logic [9:0] w_i = 10'h000;
  logic [9:0] w_q = 10'h000;
  logic [5:0] off_i = 6'h00;
  logic [5:0] off_q = 6'h00;
  logic [1:0] cm = 2'h0;
  logic [6:0] st = 7'h00;
  logic conv, conv_p, ck_i, ck_q, rx_took, tx_drv, pair, oe, upd, rdy;
  logic [9:0] tx_bus, p_i, p_q, bus_o, tx_i_o, tx_q_o;
  logic [1:0] cm_o;
  logic [19:0] rxq[$];
  logic [19:0] hist[$];
  logic [19:0] txq[$];
  int errors = 0;
  int total_checks = 0;

  always #25 sys_clk = ~sys_clk;

  iq_mux_sample_port uut (
    .sys_clk_i(sys_clk), .rst_i(rst_i), .conv_clk_i(conv),
    .rx_inphase_channel_i(rx_i), .rx_quadrature_channel_i(rx_q),
    .rx_core_valid_i(rx_valid), .rx_core_ready_o(rdy),
    .powerdown_state_i(st[0]), .idle_state_i(st[1]),
    .reference_only_state_i(st[2]), .serial_cfg_state_b_i(st[3]),
    .serial_cfg_state_d_i(st[4]), .rx_bus_enable_i(!st[5]),
    .tx_bus_enable_i(!st[6]), .tx_inphase_offset_i(off_i),
    .tx_quadrature_offset_i(off_q), .tx_common_mode_sel_i(cm),
    .rx_sample_bus_o(bus_o), .rx_sample_bus_oe_o(oe),
    .tx_sample_bus_i(tx_bus), .tx_sample_bus_driven_i(tx_drv),
    .tx_inphase_channel_o(tx_i_o), .tx_quadrature_channel_o(tx_q_o),
    .tx_update_o(upd), .tx_common_mode_o(cm_o));

  baseband_model bb (
    .sys_clk_i(sys_clk), .rst_i(rst_i), .run_i(run), .release_i(rel),
    .i_word_i(w_i), .q_word_i(w_q), .conv_clk_o(conv),
    .tx_bus_o(tx_bus), .tx_driven_o(tx_drv), .pair_o(pair),
    .pair_i_o(p_i), .pair_q_o(p_q));

  function automatic logic [9:0] sat(logic [9:0] w, logic [5:0] o);
    int s;
    s = int'(w) + int'($signed(o));
    return s < 0 ? 10'h000 : s > 1023 ? 10'h3FF : 10'(s);
  endfunction

  function automatic logic [9:0] pick();
    case ($urandom_range(3))
      0: return 10'h000;
      1: return 10'h3FF;
      default: return 10'($urandom);
    endcase
  endfunction

  task automatic check(input logic [19:0] seen, input logic [19:0] exp);
    total_checks++;
    if (seen !== exp) begin
      errors++;
      $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  task automatic print_verdict();
    $display("checks %0d, mismatches %0d", total_checks, errors);
    if (errors == 0 && total_checks > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask

  // Watcher: the pipeline history mirrors what the FIFO hands on
  always @(posedge sys_clk) begin
    if (rst_i) begin
      conv_p = 1'b0;
      ck_i = 1'b0;
      ck_q = 1'b0;
      rx_took = 1'b0;
    end else begin
      check(20'(rdy), 20'(rxq.size() != iq_port_pkg::FIFO_DEPTH));
      if (ck_i && oe && hist.size() > 5)
        check(20'(bus_o), 20'(hist[$-5][19:10]));
      if (ck_q && oe && hist.size() > 5)
        check(20'(bus_o), 20'(hist[$-5][9:0]));
      check(20'(upd), 20'(ck_i && txq.size() != 0));
      if (upd === 1'b1 && txq.size() != 0)
        check({tx_i_o, tx_q_o}, txq.pop_front());
      ck_i = conv && !conv_p;
      ck_q = !conv && conv_p;
      if (ck_i && rxq.size() != 0)
        hist.push_back(rxq.pop_front());
      else if (ck_i)
        hist.push_back(hist.size() != 0 ? hist[$] : 20'h80200);
      rx_took = rx_valid && rdy;
      if (rx_took)
        rxq.push_back({rx_i, rx_q});
      if (pair)
        txq.push_back({sat(p_i, off_i), sat(p_q, off_q)});
      conv_p = conv;
    end
  end

  always @(negedge sys_clk) begin
    if (rx_took) begin
      rx_i <= 10'($urandom);
      rx_q <= 10'($urandom);
    end
  end

  // Offsets change only while the model stands still
  task automatic run_pairs(input logic r);
    rel <= r;
    off_i <= 6'($urandom);
    off_q <= 6'($urandom);
    cm <= 2'($urandom);
    repeat (2) @(negedge sys_clk);
    check(20'(cm_o), 20'(cm));
    run <= 1'b1;
    repeat (120) begin
      @(negedge sys_clk);
      w_i <= pick();
      w_q <= pick();
    end
    run <= 1'b0;
    repeat (10) @(negedge sys_clk);
    check(20'(txq.size()), 20'h00000);
    $display("test pairs done, release %0d", r);
  endtask

  initial begin
    void'($urandom(32'hCBCFA1E8));
    repeat (20) @(posedge sys_clk);
    @(negedge sys_clk);
    rst_i <= 1'b0;
    rx_valid <= 1'b1;
    for (int k = 0; k < 3; k++)
      run_pairs(k == 2);
    for (int k = 0; k < 7; k++) begin
      st <= 7'h01 << k;
      repeat (3) @(negedge sys_clk);
      check(20'(oe), 20'(k == 6));
      if (k < 3 || k == 6)
        check({tx_i_o, tx_q_o}, 20'h80200);
      st <= 7'h00;
      repeat (2) @(negedge sys_clk);
    end
    $display("test states done");
    run_pairs(1'b0);
    print_verdict();
  end

  // The tests take under 1500 cycles; four times that means a hang
  initial begin
    #(6000 * 50);
    errors++;
    print_verdict();
  end
endmodule
`default_nettype wire
